// file: pkg/ics_regs.svh
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

// System clock and one-second timebase
`define ICS_CLK_HZ 20000000
`define ICS_TICK_S 1

// Sequence times, in seconds
`define ICS_HG_OFF_S 8'd5
`define ICS_SLUSH_S 8'd30
`define ICS_THICK_S 8'd5
`define ICS_RECLOSE_S 8'd30
`define ICS_PUMPDN_S 8'd30
`define ICS_DRAIN_S 8'd8
`define ICS_PURGE_DLY_S 8'd4
`define ICS_PURGE_STEP_S 8'd6

// Cycles allowed for the self check to settle after reset
`define ICS_SELF_CYC 4'd8

// Register byte offsets
`define ICS_CTRL_OFS 8'h00
`define ICS_STAT_OFS 8'h04
`define ICS_COND_OFS 8'h08

// Control register fields and reset value
`define ICS_CTRL_REMOTE 0
`define ICS_CTRL_TWO_EVAP 1
`define ICS_CTRL_PURGE_LSB 4
`define ICS_CTRL_MASK 8'h73
`define ICS_CTRL_RST 8'h00

`endif

// file: pkg/ics_pkg.sv
package ics_pkg;

    // Main sequencer states
    typedef enum logic [3:0] {
        ICS_SELFCHK,
        ICS_FAULT,
        ICS_STANDBY,
        ICS_DRAIN,
        ICS_FILL,
        ICS_FREEZE,
        ICS_HARVEST,
        ICS_POSTHARV,
        ICS_PUMPDOWN
    } ics_state_t;

    // Anti-slush phase within one freeze
    typedef enum logic [1:0] {
        ICS_SL_PRE,
        ICS_SL_PAUSE,
        ICS_SL_POST
    } ics_slush_t;

    // Character on the code display
    typedef enum logic [3:0] {
        ICS_DISP_BLANK,
        ICS_DISP_ZERO,
        ICS_DISP_E,
        ICS_DISP_F,
        ICS_DISP_H,
        ICS_DISP_B
    } ics_disp_t;

endpackage : ics_pkg

// file: rtl/ics_sync.sv
`timescale 1ns/100ps
module ics_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw pins and filtered result
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ics_sync_regs_t;

    ics_sync_regs_t r;
    ics_sync_regs_t next_r;

    // Three stages; a bit moves only once stages two and three agree
    always_comb begin
        next_r = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;
endmodule : ics_sync

// file: rtl/ics_sequencer.sv
// Function
// - Power-up self check; fail shows E and halts, pass shows 0 with lights.
// - Press and release On starts ice making; display blinks F meanwhile.
// - Startup drains with purge and pump, hot gas on, then stops drain.
// - Inlet valve opens when mid probe dry, closes when top probe wet.
// - Reservoir full stops inlet, starts compressor; hot gas off five seconds later.
// - Remote models switch liquid line valve on with compressor and pump.
// - Freeze shows steady F with power and status lit; harvest shows steady H.
// - Cold water in freeze stops the pump for 30 seconds, then restarts it.
// - Pump-off pause samples reservoir conductivity for the automatic purge time.
// - After the pause neither sump light shows for the rest of freeze.
// - Thickness probe wet blinks ready light; 5 seconds continuous enters harvest.
// - Harvest energizes hot gas for the whole harvest.
// - Non-remote models switch the condenser fan off throughout harvest.
// - Some seconds into harvest, purge and pump run for the purge time.
// - Ready light goes off when the curtain opens.
// - One curtain opening ends harvest; two-evaporator machines need both opened.
// - Harvest completion de-energizes hot gas, purge and pump.
// - Curtain closing within 30 seconds restarts freeze, otherwise standby bin full.
// - Remote shutdown closes liquid line valve, pumps down 30 seconds, stops compressor.
`timescale 1ns/100ps
`include "ics_regs.svh"
module ics_sequencer import ics_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `ICS_CLK_HZ * `ICS_TICK_S,
    parameter logic [7:0] DRAIN_S = `ICS_DRAIN_S,
    parameter logic [7:0] PURGE_DLY_S = `ICS_PURGE_DLY_S,
    parameter logic [7:0] PURGE_STEP_S = `ICS_PURGE_STEP_S,
    parameter logic [7:0] HG_OFF_S = `ICS_HG_OFF_S,
    parameter logic [7:0] SLUSH_S = `ICS_SLUSH_S,
    parameter logic [7:0] THICK_S = `ICS_THICK_S,
    parameter logic [7:0] RECLOSE_S = `ICS_RECLOSE_S,
    parameter logic [7:0] PUMPDN_S = `ICS_PUMPDN_S
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sensor and button pins, active high
    input wire logic mid_wet_i,
    input wire logic top_wet_i,
    input wire logic thick_wet_i,
    input wire logic water_cold_i,
    input wire logic curtain1_closed_i,
    input wire logic curtain2_closed_i,
    input wire logic on_btn_i,
    input wire logic self_ok_i,
    // Conductivity sample from on-chip converter
    input wire logic [7:0] cond_i,
    // Actuators
    output logic compressor_o,
    output logic pump_o,
    output logic purge_o,
    output logic inlet_o,
    output logic hot_gas_o,
    output logic fan_llv_o,
    // Display
    output ics_disp_t disp_code_o,
    output logic disp_blink_o,
    // Indicator lights
    output logic led_power_o,
    output logic led_status_o,
    output logic led_comp_o,
    output logic led_pump_o,
    output logic led_purge_o,
    output logic led_inlet_o,
    output logic led_hot_gas_o,
    output logic led_fan_llv_o,
    output logic led_ready_o,
    output logic led_sump_empty_o,
    output logic led_sump_full_o,
    output logic led_curtain1_o,
    output logic led_curtain2_o
);
    localparam int DW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        ics_state_t st;
        logic [DW-1:0] div;
        logic tick;
        logic blk;
        logic [3:0] sc;
        logic [7:0] tm;
        logic [7:0] slt;
        logic [7:0] thk;
        logic [7:0] ptm;
        ics_slush_t sl;
        logic comp;
        logic pump;
        logic purge;
        logic inlet;
        logic hg;
        logic fan;
        logic ready;
        logic c1_open;
        logic c2_open;
        logic pdone;
        logic bin_full;
        logic self_pass;
        logic btn_q;
        logic [7:0] cond;
        ics_disp_t disp;
        logic dblink;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] ctrl;
    } ics_regs_t;

    ics_regs_t r;
    ics_regs_t next_r;
    logic [7:0] pin_raw;
    logic [7:0] pin_s;
    logic s_mid, s_top, s_thick, s_cold, s_c1, s_c2, s_on, s_ok;
    logic remote, two_evap, cur_closed, harv_end, req;
    logic [2:0] purge_set;

    // True on the tick that completes a count of lim seconds
    function automatic logic expired(input logic tk, input logic [7:0] t,
                                     input logic [7:0] lim);
        return tk && (({1'b0, t} + 9'd1) >= {1'b0, lim});
    endfunction : expired

    // Purge length: manual settings scale by step, automatic follows conductivity
    function automatic logic [7:0] purge_len(input logic [2:0] set,
                                             input logic [7:0] cond);
        logic [10:0] p;
        p = '0;
        if (set == 3'd0) begin
            p = 11'({1'b0, cond[7:6]} + 3'd2) * 11'(PURGE_STEP_S);
        end else begin
            p = 11'(set) * 11'(PURGE_STEP_S);
        end
        return (p > 11'd255) ? 8'hff : p[7:0];
    endfunction : purge_len

    // Code shown for a state
    function automatic ics_disp_t disp_of(input ics_state_t st, input logic bin);
        ics_disp_t d;
        d = ICS_DISP_BLANK;
        case (st)
            ICS_FAULT: d = ICS_DISP_E;
            ICS_STANDBY: d = bin ? ICS_DISP_B : ICS_DISP_ZERO;
            ICS_DRAIN, ICS_FILL, ICS_FREEZE: d = ICS_DISP_F;
            ICS_HARVEST, ICS_POSTHARV: d = ICS_DISP_H;
            ICS_PUMPDOWN: d = ICS_DISP_B;
            default: d = ICS_DISP_BLANK;
        endcase
        return d;
    endfunction : disp_of

    // Pins from outside the clock domain pass the three-stage filter
    assign pin_raw = {self_ok_i, on_btn_i, curtain2_closed_i, curtain1_closed_i,
                      water_cold_i, thick_wet_i, top_wet_i, mid_wet_i};

    ics_sync #(
        .W(8)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    // Filtered pins and configuration fields
    assign {s_ok, s_on, s_c2, s_c1, s_cold, s_thick, s_top, s_mid} = pin_s;
    assign remote = r.ctrl[`ICS_CTRL_REMOTE];
    assign two_evap = r.ctrl[`ICS_CTRL_TWO_EVAP];
    assign purge_set = r.ctrl[`ICS_CTRL_PURGE_LSB +: 3];
    // A single curtain may sit on either input, so the idle input reads open
    assign cur_closed = two_evap ? (s_c1 & s_c2) : (s_c1 | s_c2);
    assign req = wb_cyc_i & wb_stb_i;

    always_comb begin
        next_r = r;
        harv_end = 1'b0;
        // One-second timebase shared by every delay except the self check, which counts clock cycles
        next_r.tick = 1'b0;
        if (r.div == DW'(TICK_CYCLES - 1)) begin
            next_r.div = '0;
            next_r.tick = 1'b1;
            next_r.blk = ~r.blk;
        end else begin
            next_r.div = r.div + 1'b1;
        end
        if (r.tick && r.tm != 8'hff) begin
            next_r.tm = r.tm + 8'd1;
        end
        next_r.btn_q = s_on;

        case (r.st)
            ICS_SELFCHK: begin
                // Let the pin filter settle before judging the check
                next_r.sc = r.sc + 4'd1;
                if (r.sc == `ICS_SELF_CYC) begin
                    next_r.self_pass = s_ok;
                    next_r.st = s_ok ? ICS_STANDBY : ICS_FAULT;
                end
            end
            ICS_FAULT: begin
                next_r.st = ICS_FAULT; // No way out but reset
            end
            ICS_STANDBY: begin
                // Start on release, not press
                if (r.btn_q && !s_on) begin
                    next_r.st = ICS_DRAIN;
                    next_r.tm = '0;
                    next_r.bin_full = 1'b0;
                    next_r.purge = 1'b1;
                    next_r.pump = 1'b1;
                    next_r.hg = 1'b1;
                end
            end
            ICS_DRAIN: begin
                if (expired(r.tick, r.tm, DRAIN_S)) begin
                    next_r.purge = 1'b0;
                    next_r.pump = 1'b0;
                    next_r.st = ICS_FILL;
                    next_r.tm = '0;
                end
            end
            ICS_FILL: begin
                if (s_top) begin
                    next_r.st = ICS_FREEZE;
                    next_r.tm = '0;
                    next_r.comp = 1'b1;
                    next_r.pump = 1'b1;
                    next_r.fan = 1'b1; // Liquid line valve on remote models
                    next_r.sl = ICS_SL_PRE;
                    next_r.thk = '0;
                end
            end
            ICS_FREEZE: begin
                // Hot gas held only for the first seconds of compressor run
                if (r.hg && expired(r.tick, r.tm, HG_OFF_S)) begin
                    next_r.hg = 1'b0;
                end
                // Anti-slush pause
                if (r.sl == ICS_SL_PRE && s_cold) begin
                    next_r.sl = ICS_SL_PAUSE;
                    next_r.pump = 1'b0;
                    next_r.slt = '0;
                    next_r.cond = cond_i;
                end else if (r.sl == ICS_SL_PAUSE) begin
                    if (r.tick) begin
                        next_r.slt = r.slt + 8'd1;
                    end
                    if (expired(r.tick, r.slt, SLUSH_S)) begin
                        next_r.pump = 1'b1;
                        next_r.sl = ICS_SL_POST;
                    end
                end
                // Thickness must hold without a break
                if (!s_thick) begin
                    next_r.thk = '0;
                end else if (r.tick) begin
                    next_r.thk = r.thk + 8'd1;
                end
                if (s_thick && expired(r.tick, r.thk, THICK_S)) begin
                    next_r.st = ICS_HARVEST;
                    next_r.tm = '0;
                    next_r.hg = 1'b1;
                    next_r.fan = remote;
                    next_r.pump = 1'b0;
                    next_r.ready = 1'b1;
                    next_r.c1_open = 1'b0;
                    next_r.c2_open = 1'b0;
                    next_r.pdone = 1'b0;
                end
            end
            ICS_HARVEST: begin
                // Purge starts a few seconds in and runs its set length
                if (!r.purge && !r.pdone && expired(r.tick, r.tm, PURGE_DLY_S)) begin
                    next_r.purge = 1'b1;
                    next_r.pump = 1'b1;
                    next_r.ptm = '0;
                end else if (r.purge) begin
                    if (r.tick) begin
                        next_r.ptm = r.ptm + 8'd1;
                    end
                    if (expired(r.tick, r.ptm, purge_len(purge_set, r.cond))) begin
                        next_r.purge = 1'b0;
                        next_r.pump = 1'b0;
                        next_r.pdone = 1'b1;
                    end
                end
                // Latch each curtain opening
                if (!s_c1) begin
                    next_r.c1_open = 1'b1;
                end
                if (!s_c2) begin
                    next_r.c2_open = 1'b1;
                end
                if (two_evap) begin
                    harv_end = next_r.c1_open & next_r.c2_open;
                    if (next_r.c1_open | next_r.c2_open) begin
                        next_r.ready = 1'b0;
                    end
                end else begin
                    harv_end = !cur_closed;
                    if (harv_end) begin
                        next_r.ready = 1'b0;
                    end
                end
                if (harv_end) begin
                    next_r.hg = 1'b0;
                    next_r.purge = 1'b0;
                    next_r.pump = 1'b0;
                    next_r.ready = 1'b0;
                    next_r.st = ICS_POSTHARV;
                    next_r.tm = '0;
                end
            end
            ICS_POSTHARV: begin
                if (cur_closed) begin
                    next_r.st = ICS_FREEZE;
                    next_r.tm = '0;
                    next_r.pump = 1'b1;
                    next_r.fan = 1'b1;
                    next_r.sl = ICS_SL_PRE;
                    next_r.thk = '0;
                end else if (expired(r.tick, r.tm, RECLOSE_S)) begin
                    next_r.bin_full = 1'b1;
                    next_r.fan = 1'b0;
                    next_r.tm = '0;
                    if (remote) begin
                        next_r.st = ICS_PUMPDOWN;
                    end else begin
                        next_r.comp = 1'b0;
                        next_r.st = ICS_STANDBY;
                    end
                end
            end
            ICS_PUMPDOWN: begin
                // Compressor empties the low side with the valve shut
                if (expired(r.tick, r.tm, PUMPDN_S)) begin
                    next_r.comp = 1'b0;
                    next_r.st = ICS_STANDBY;
                end
            end
            default: begin
                next_r.st = ICS_SELFCHK;
            end
        endcase

        // Refill runs beside the main sequence; set wins over clear
        case (next_r.st)
            ICS_DRAIN, ICS_FILL, ICS_FREEZE, ICS_HARVEST, ICS_POSTHARV: begin
                if (!s_mid) begin
                    next_r.inlet = 1'b1;
                end else if (s_top) begin
                    next_r.inlet = 1'b0;
                end
            end
            default: begin
                next_r.inlet = 1'b0;
            end
        endcase

        // Display follows the state it is about to hold
        next_r.disp = disp_of(next_r.st, next_r.bin_full);
        next_r.dblink = (next_r.st == ICS_DRAIN) || (next_r.st == ICS_FILL);

        // Wishbone: ack one cycle after the request, write at the acked edge
        next_r.ack = req & ~r.ack;
        if (req && r.ack && wb_we_i && wb_adr_i == `ICS_CTRL_OFS && wb_sel_i[0]) begin
            next_r.ctrl = wb_dat_i[7:0] & `ICS_CTRL_MASK;
        end
        case (wb_adr_i)
            `ICS_CTRL_OFS: next_r.rdat = {24'h000000, r.ctrl};
            `ICS_STAT_OFS: next_r.rdat = {16'h0000, 2'(r.sl), r.bin_full,
                                          r.self_pass, 4'(r.disp), 3'h0,
                                          r.dblink, 4'(r.st)};
            `ICS_COND_OFS: next_r.rdat = {24'h000000, r.cond};
            default: next_r.rdat = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.ctrl <= `ICS_CTRL_RST;
        end else begin
            r <= next_r;
        end
    end

    // Actuators and display straight from state
    assign compressor_o = r.comp;
    assign pump_o = r.pump;
    assign purge_o = r.purge;
    assign inlet_o = r.inlet;
    assign hot_gas_o = r.hg;
    assign fan_llv_o = r.fan;
    assign disp_code_o = r.disp;
    assign disp_blink_o = r.dblink;
    assign wb_dat_o = r.rdat;
    assign wb_ack_o = r.ack;

    // Component lights track the actuators in the same cycle
    assign led_comp_o = r.comp;
    assign led_pump_o = r.pump;
    assign led_purge_o = r.purge;
    assign led_inlet_o = r.inlet;
    assign led_hot_gas_o = r.hg;
    assign led_fan_llv_o = r.fan;

    // Status lights
    assign led_power_o = r.self_pass;
    assign led_status_o = (r.st == ICS_FREEZE) || (r.st == ICS_HARVEST);
    assign led_ready_o = r.ready || ((r.st == ICS_FREEZE) && s_thick && r.blk);
    assign led_sump_empty_o = (r.st == ICS_STANDBY);
    assign led_sump_full_o = (r.st == ICS_FREEZE) && (r.sl != ICS_SL_POST) && s_top;
    assign led_curtain1_o = r.self_pass & s_c1;
    assign led_curtain2_o = r.self_pass & s_c2;
endmodule : ics_sequencer

// file: sim/ics_sequencer_checker.sv
`timescale 1ns/100ps
module ics_sequencer_checker import ics_pkg::*; #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Probes
    input wire logic mid_wet_i,
    input wire logic top_wet_i,
    // Actuators
    input wire logic compressor_o,
    input wire logic pump_o,
    input wire logic purge_o,
    input wire logic inlet_o,
    input wire logic hot_gas_o,
    input wire logic fan_llv_o,
    // Display and lights
    input wire ics_disp_t disp_code_o,
    input wire logic led_power_o,
    input wire logic led_status_o,
    input wire logic led_ready_o,
    input wire logic led_sump_empty_o,
    input wire logic led_comp_o,
    input wire logic led_pump_o,
    input wire logic led_purge_o,
    input wire logic led_inlet_o,
    input wire logic led_hot_gas_o,
    input wire logic led_fan_llv_o
);
    // Windows allow a short first second plus the pin filter
    localparam int S30_LO = 29 * TICK_CYCLES - 2;
    localparam int S30_HI = 30 * TICK_CYCLES + 4;
    localparam int S5_LO = 4 * TICK_CYCLES - 2;
    localparam int S5_HI = 5 * TICK_CYCLES + 4;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Lights follow their actuators in the same cycle
    AST_LED_MIRROR: assert property (
        led_comp_o == compressor_o && led_pump_o == pump_o && led_purge_o == purge_o
        && led_inlet_o == inlet_o && led_hot_gas_o == hot_gas_o
        && led_fan_llv_o == fan_llv_o) else $error("light differs from actuator");
    AST_STANDBY: assert property (disp_code_o == ICS_DISP_ZERO |->
        led_power_o && led_sump_empty_o && !compressor_o && !pump_o)
        else $error("standby lights wrong");
    AST_HARV_HG: assert property (disp_code_o == ICS_DISP_H && led_ready_o |->
        hot_gas_o && led_status_o) else $error("hot gas off in harvest");
    // Both probes wet long enough to pass the filter closes the inlet
    AST_INLET_STOP: assert property ((top_wet_i && mid_wet_i) [*7] |=> !inlet_o)
        else $error("inlet open with sump full");
    AST_INLET_SET: assert property ((!mid_wet_i) [*7] ##0 led_status_o |=> inlet_o)
        else $error("inlet closed with sump low");
    AST_SLUSH: assert property ($fell(pump_o) && led_status_o &&
        disp_code_o == ICS_DISP_F |-> ##[S30_LO:S30_HI] $rose(pump_o))
        else $error("anti-slush pause length wrong");
    AST_HG_OFF: assert property ($rose(compressor_o) |->
        ##[S5_LO:S5_HI] $fell(hot_gas_o)) else $error("hot gas not dropped on time");
    AST_END_HG: assert property ($fell(led_status_o) |-> !hot_gas_o && !purge_o)
        else $error("hot gas left on after harvest");
    AST_PUMPDN: assert property ($fell(fan_llv_o) && compressor_o && !led_status_o |->
        ##[S30_LO:S30_HI] $fell(compressor_o)) else $error("pump down length wrong");
endmodule : ics_sequencer_checker

bind ics_sequencer ics_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
    .clk_i, .rst_i, .mid_wet_i, .top_wet_i, .compressor_o, .pump_o, .purge_o, .inlet_o,
    .hot_gas_o, .fan_llv_o, .disp_code_o, .led_power_o, .led_status_o, .led_ready_o,
    .led_sump_empty_o, .led_comp_o, .led_pump_o, .led_purge_o, .led_inlet_o,
    .led_hot_gas_o, .led_fan_llv_o);

// file: sim/ics_plant.sv
`timescale 1ns/100ps
module ics_plant (
    // Clock
    input wire logic clk_i,
    // Valve and pump drives
    input wire logic inlet_i,
    input wire logic pump_i,
    input wire logic purge_i,
    // Probe readings
    output logic mid_wet_o,
    output logic top_wet_o
);
    int level = 40;
    // Draining outruns the inlet, so a purge really empties the sump
    always @(posedge clk_i) begin
        if (purge_i && pump_i && level > 1) begin
            level <= level - 2 + int'(inlet_i);
        end else if (inlet_i && level < 40) begin
            level <= level + 1;
        end
    end
    // Mid dry asks for refill, top wet means sump full
    assign mid_wet_o = level >= 20;
    assign top_wet_o = level >= 40;
endmodule : ics_plant

// file: sim/tb_ics_sequencer.sv
`timescale 1ns/100ps
module tb_ics_sequencer import ics_pkg::*;;
    localparam int T = 10;
    // Bench drives
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ok = 1, on = 0;
    logic thick = 0, cold = 0, c1 = 1, c2 = 1;
    logic [7:0] adr = 8'h00, cond = 8'hc3;
    logic [31:0] wdat = 32'h0, rdat, got;
    logic [3:0] sel = 4'h0;
    // Design outputs and probes
    logic ack, mid, top, comp, pump, purge, inlet, hg, fan, blink;
    logic pwr, status, rdy, empty, full, lc1, lc2;
    logic [1:0] seen;
    ics_disp_t disp;
    int error_cnt = 0, cmp_count = 0, n;

    always #25 clk_i = ~clk_i;

    ics_sequencer #(.TICK_CYCLES(T)) uut (
        .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mid_wet_i(mid), .top_wet_i(top), .thick_wet_i(thick), .water_cold_i(cold),
        .curtain1_closed_i(c1), .curtain2_closed_i(c2), .on_btn_i(on), .self_ok_i(ok),
        .cond_i(cond), .compressor_o(comp), .pump_o(pump), .purge_o(purge),
        .inlet_o(inlet), .hot_gas_o(hg), .fan_llv_o(fan), .disp_code_o(disp),
        .disp_blink_o(blink), .led_power_o(pwr), .led_status_o(status), .led_comp_o(),
        .led_pump_o(), .led_purge_o(), .led_inlet_o(), .led_hot_gas_o(),
        .led_fan_llv_o(), .led_ready_o(rdy), .led_sump_empty_o(empty),
        .led_sump_full_o(full), .led_curtain1_o(lc1), .led_curtain2_o(lc2));
    ics_plant plant (.clk_i, .inlet_i(inlet), .pump_i(pump), .purge_i(purge),
        .mid_wet_o(mid), .top_wet_o(top));

    // Count a comparison, report a mismatch at once
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Classic cycle: hold until ack is sampled, take data at that edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        got = rdat;
        chk(ack, 1'b1);
        cyc <= 0;
        stb <= 0;
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(got & m, e);
    endtask : rd

    // Bounded wait on a settled level; n holds the cycles taken
    task automatic await(ref logic s, input logic v, input int lim);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (s !== v && n < lim);
        chk(s, v);
    endtask : await

    // Long enough to pass the pin filter
    task press();
        @(posedge clk_i);
        on <= 1;
        repeat (8) @(posedge clk_i);
        on <= 0;
    endtask : press

    task summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // About four times the expected run
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        repeat (14) @(negedge clk_i);
        chk(disp, ICS_DISP_ZERO);
        chk({pwr, empty, lc1, lc2, comp, pump, blink}, 7'b1111000);
        rd(8'h00, 32'hff, 32'h0);
        rd(8'h0c, 32'hffffffff, 32'h0);
        wb(1'b1, 8'h04, 32'hffff);
        rd(8'h04, 32'h300f, 32'h1002);
        press();
        repeat (10) @(negedge clk_i);
        chk({disp, blink, purge, pump, hg, comp}, {ICS_DISP_F, 5'b11110});
        await(inlet, 1'b1, 60);
        await(purge, 1'b0, 120);
        chk({pump, hg}, 2'b01);
        await(comp, 1'b1, 150);
        chk({disp, blink, inlet, pump, fan, hg}, {ICS_DISP_F, 5'b00111});
        chk({pwr, status, full}, 3'b111);
        await(hg, 1'b0, 80);
        chk(n >= 38 && n <= 53, 1'b1);
        @(posedge clk_i);
        cold <= 1;
        await(pump, 1'b0, 20);
        @(posedge clk_i);
        cond <= 8'h11;
        await(pump, 1'b1, 400);
        chk(n >= 285 && n <= 305, 1'b1);
        chk({full, empty}, 2'b00);
        rd(8'h08, 32'hff, 32'hc3);
        cold <= 0;
        thick <= 1;
        seen = 2'b00;
        repeat (30) begin
            @(negedge clk_i);
            seen[rdy] = 1'b1;
        end
        chk(seen, 2'b11);
        await(hg, 1'b1, 40);
        chk(n >= 8 && n <= 27, 1'b1);
        chk({disp, rdy, status, fan, pump, comp}, {ICS_DISP_H, 5'b11001});
        await(purge, 1'b1, 60);
        chk({n >= 28 && n <= 43, pump}, 2'b11);
        await(purge, 1'b0, 400);
        chk({n >= 288 && n <= 303, hg}, 2'b11);
        @(posedge clk_i);
        thick <= 0;
        c1 <= 0;
        c2 <= 0;
        await(hg, 1'b0, 20);
        chk({rdy, purge, pump}, 3'b000);
        repeat (50) @(posedge clk_i);
        c1 <= 1;
        c2 <= 1;
        await(status, 1'b1, 20);
        chk({disp, comp}, {ICS_DISP_F, 1'b1});
        wb(1'b1, 8'h00, 32'h13);
        rd(8'h00, 32'hff, 32'h13);
        thick <= 1;
        await(hg, 1'b1, 80);
        chk({fan, comp}, 2'b11);
        await(purge, 1'b1, 60);
        await(purge, 1'b0, 100);
        chk(n >= 48 && n <= 63, 1'b1);
        @(posedge clk_i);
        thick <= 0;
        c1 <= 0;
        repeat (20) @(negedge clk_i);
        chk(hg, 1'b1);
        @(posedge clk_i);
        c2 <= 0;
        await(hg, 1'b0, 20);
        await(fan, 1'b0, 320);
        chk({n >= 285 && n <= 305, comp}, 2'b11);
        await(comp, 1'b0, 320);
        chk({n >= 285 && n <= 305, disp}, {1'b1, ICS_DISP_B});
        rd(8'h04, 32'h200f, 32'h2002);
        @(posedge clk_i);
        rst_i <= 1;
        ok <= 0;
        c1 <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        repeat (14) @(negedge clk_i);
        press();
        repeat (10) @(negedge clk_i);
        chk({disp, pwr, lc1, comp, pump, purge, hg}, {ICS_DISP_E, 6'b0});
        summarize();
    end
endmodule : tb_ics_sequencer
